// [slcs_defs.vh]
// Overview of operation
// - status bits 25:24 give source target kind
// - bits 23:16 show destination link while busy
// - external links have writable direction 11:8
// - every link has writable network 5:4
// - bit 2 flags junk packet; discarded on external links only
// - bit 1 destination busy, bit 0 source busy
// - processor link status lacks direction, 15:6 reserved
// - config bit 31 enables link, muxes pins
// - config bit 30 selects two or five wire
// - bit 27 flags overflow or illegal token
// - bit 26 shows credit issued to remote
// - bit 25 shows credit held for transmit
// - write bit 24 clears credit, sends reset token
// - write bit 23 resets the receiver
// - bits 21:11 plus one: symbol gap
// - bits 10:0 plus one: token gap
// - static bit 31 forwards link to channel end
// - static bit 8 processor, bits 4:0 channel end
// - static registers order links C D A B G H E F
// - route by top mismatching destination bit
`ifndef SLCS_DEFS_VH
`define SLCS_DEFS_VH
`define SLCS_AW 8
`define SLCS_STAT_BASE 8'h20
`define SLCS_PSTAT_BASE 8'h40
`define SLCS_CFG_BASE 8'h80
`define SLCS_STATIC_BASE 8'hA0
`define SLCS_DIRS_LO 8'h0C
`define SLCS_DIRS_HI 8'h0D
`define SLCS_NODE_ID 8'h05
`define SLCS_NLINK 8
`define SLCS_SRC_HI 25
`define SLCS_SRC_LO 24
`define SLCS_DEST_HI 23
`define SLCS_DEST_LO 16
`define SLCS_DIR_HI 11
`define SLCS_DIR_LO 8
`define SLCS_NET_HI 5
`define SLCS_NET_LO 4
`define SLCS_JUNK 2
`define SLCS_DBUSY 1
`define SLCS_SBUSY 0
`define SLCS_EN 31
`define SLCS_WIDE 30
`define SLCS_ERR 27
`define SLCS_CRED_ISS 26
`define SLCS_CRED_HAVE 25
`define SLCS_CREDIT_RESET_TOKEN 24
`define SLCS_RXRST 23
`define SLCS_SYMGAP_HI 21
`define SLCS_SYMGAP_LO 11
`define SLCS_TOKGAP_HI 10
`define SLCS_TOKGAP_LO 0
`define SLCS_ST_EN 31
`define SLCS_ST_PROC 8
`define SLCS_ST_CHAN_HI 4
`define SLCS_ST_CHAN_LO 0
`define SLCS_KIND_SWITCH 2'h0
`define SLCS_KIND_PROC 2'h1
`define SLCS_KIND_CTRL 2'h2
`define SLCS_KIND_UNDEF 2'h3
`endif

// [slcs_tx_pacer.v]
`timescale 1ns/1ps
`include "slcs_defs.vh"
// paces one link's transmitter: idle gap between symbols and tokens
module slcs_tx_pacer (
	input wire ref_clk_i, // system clock
	input wire rst_n_i, // async reset, active low
	input wire enable_i, // link enabled
	input wire [10:0] sym_gap_i, // idle clocks minus one between symbols
	input wire [10:0] tok_gap_i, // idle clocks minus one between tokens
	input wire sym_sent_i, // a symbol left this cycle
	input wire tok_last_i, // that symbol ended a token
	output reg ready_o // next symbol may go
);
	reg [11:0] cnt_r;
	// load gap+1 after each symbol, count down to zero; a sent symbol reloads
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 12'h000;
			ready_o <= 1'b0;
		end else if (!enable_i) begin
			cnt_r <= 12'h000;
			ready_o <= 1'b0;
		end else if (sym_sent_i) begin
			cnt_r <= tok_last_i ? {1'b0, tok_gap_i} + 12'h001 : {1'b0, sym_gap_i} + 12'h001;
			ready_o <= 1'b0;
		end else if (cnt_r != 12'h000) begin
			cnt_r <= cnt_r - 12'h001;
			ready_o <= (cnt_r == 12'h001);
		end else begin
			ready_o <= 1'b1;
		end
	end
endmodule // slcs_tx_pacer

// [slcs_link_cfg.v]
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "slcs_defs.vh"
// per-link configuration and status block of the packet switch
module slcs_link_cfg (
	input wire ref_clk_i, // system switch clock, 100 MHz
	input wire rst_n_i, // async reset, active low
	input wire [7:0] addr_i, // register address
	input wire [31:0] wdata_i, // write data
	input wire wr_i, // write strobe
	input wire rd_i, // read strobe
	output reg [31:0] rdata_o, // read data, cycle after rd_i
	input wire [15:0] node_id_i, // this node identifier
	input wire [15:0] pkt_dest_i, // destination of routed packet header
	output reg [3:0] route_dir_o, // direction chosen for routed packet
	output reg route_local_o, // destination equals this node
	input wire [7:0] ext_src_busy_i, // source side busy per external link
	input wire [7:0] ext_dst_busy_i, // destination side busy per external link
	input wire [7:0] ext_junk_i, // current packet is junk
	input wire [63:0] ext_dest_link_i, // destination link number, 8 per link
	input wire [7:0] ext_rx_overflow_i, // receive buffer overflow pulse
	input wire [7:0] ext_rx_illegal_i, // illegal token encoding pulse
	input wire [7:0] ext_credit_issued_i, // credit issued event
	input wire [7:0] ext_credit_got_i, // credit received event
	input wire [7:0] ext_sym_sent_i, // symbol transmitted
	input wire [7:0] ext_tok_last_i, // transmitted symbol ended a token
	input wire [7:0] plk_src_busy_i, // processor link source busy
	input wire [7:0] plk_dst_busy_i, // processor link destination busy
	input wire [7:0] plk_junk_i, // processor link junk packet
	input wire [63:0] plk_dest_link_i, // processor link destination, 8 per link
	output reg [7:0] link_en_o, // link enabled, also pin mux select
	output reg [7:0] link_wide_o, // 1 five wire, 0 two wire
	output reg [7:0] tx_ready_o, // transmitter may send next symbol
	output reg [7:0] send_credit_reset_token_o, // pulse: send credit reset token
	output reg [7:0] rx_reset_o, // pulse: reset receiver
	output reg [7:0] junk_drop_o, // discard current packet
	output reg [7:0] static_en_o, // static forwarding per link (C D A B G H E F)
	output reg [7:0] static_proc_o, // static destination processor
	output reg [39:0] static_chan_o, // static channel ends, 5 per link
	output reg [31:0] net_o // network numbers, ext 15:0 then proc 31:16
);
	////////////////////////////////////////////////////////////////////////
	// decode helpers
	// index of an address inside an 8-entry window, or 4'hF if outside
	function [3:0] win_idx;
		input [7:0] a;
		input [7:0] base;
		begin
			if (a >= base && a < base + 8'h08)
				win_idx = {1'b0, a[2:0] - base[2:0]};
			else
				win_idx = 4'hF;
		end
	endfunction

	// highest bit at which two ids differ; bit 4 flags "equal"
	function [4:0] top_diff;
		input [15:0] x;
		integer k;
		begin
			top_diff = 5'h10;
			for (k = 0; k < 16; k = k + 1)
				if (x[k])
					top_diff = k[4:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register storage
	reg [3:0] dir_r [0:7];
	reg [1:0] net_r [0:7];
	reg [1:0] pnet_r [0:7];
	reg [10:0] symgap_r [0:7];
	reg [10:0] tokgap_r [0:7];
	reg [7:0] err_r;
	reg [7:0] cred_iss_r;
	reg [7:0] cred_have_r;
	reg [31:0] dirs_lo_r;
	reg [31:0] dirs_hi_r;
	wire [3:0] stat_i = win_idx(addr_i, `SLCS_STAT_BASE);
	wire [3:0] pstat_i = win_idx(addr_i, `SLCS_PSTAT_BASE);
	wire [3:0] cfg_i = win_idx(addr_i, `SLCS_CFG_BASE);
	wire [3:0] st_i = win_idx(addr_i, `SLCS_STATIC_BASE);
	wire [7:0] pace_rdy;
	integer i;

	////////////////////////////////////////////////////////////////////////
	// software writable fields; reserved bits are never stored
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (i = 0; i < 8; i = i + 1) begin
				dir_r[i] <= 4'h0;
				net_r[i] <= 2'h0;
				pnet_r[i] <= 2'h0;
				symgap_r[i] <= 11'h000;
				tokgap_r[i] <= 11'h000;
			end
			link_en_o <= 8'h00;
			link_wide_o <= 8'h00;
			static_en_o <= 8'h00;
			static_proc_o <= 8'h00;
			static_chan_o <= 40'h0000000000;
			dirs_lo_r <= 32'h00000000;
			dirs_hi_r <= 32'h00000000;
		end else if (wr_i) begin
			if (!stat_i[3]) begin
				dir_r[stat_i[2:0]] <= wdata_i[`SLCS_DIR_HI:`SLCS_DIR_LO];
				net_r[stat_i[2:0]] <= wdata_i[`SLCS_NET_HI:`SLCS_NET_LO];
			end
			if (!pstat_i[3])
				pnet_r[pstat_i[2:0]] <= wdata_i[`SLCS_NET_HI:`SLCS_NET_LO];
			if (!cfg_i[3]) begin
				link_en_o[cfg_i[2:0]] <= wdata_i[`SLCS_EN];
				link_wide_o[cfg_i[2:0]] <= wdata_i[`SLCS_WIDE];
				symgap_r[cfg_i[2:0]] <= wdata_i[`SLCS_SYMGAP_HI:`SLCS_SYMGAP_LO];
				tokgap_r[cfg_i[2:0]] <= wdata_i[`SLCS_TOKGAP_HI:`SLCS_TOKGAP_LO];
			end
			// index 0 is link C, ..., 7 is link F; upstream maps letters
			if (!st_i[3]) begin
				static_en_o[st_i[2:0]] <= wdata_i[`SLCS_ST_EN];
				static_proc_o[st_i[2:0]] <= wdata_i[`SLCS_ST_PROC];
				static_chan_o[st_i[2:0]*5 +: 5] <= wdata_i[`SLCS_ST_CHAN_HI:`SLCS_ST_CHAN_LO];
			end
			if (addr_i == `SLCS_DIRS_LO)
				dirs_lo_r <= wdata_i;
			if (addr_i == `SLCS_DIRS_HI)
				dirs_hi_r <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// action pulses and sticky link status; a hardware set beats a clear
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			send_credit_reset_token_o <= 8'h00;
			rx_reset_o <= 8'h00;
			err_r <= 8'h00;
			cred_iss_r <= 8'h00;
			cred_have_r <= 8'h00;
		end else begin
			for (i = 0; i < 8; i = i + 1) begin
				send_credit_reset_token_o[i] <= wr_i && cfg_i == i && wdata_i[`SLCS_CREDIT_RESET_TOKEN];
				rx_reset_o[i] <= wr_i && cfg_i == i && wdata_i[`SLCS_RXRST];
				// error stays up until the receiver is reset
				if (ext_rx_overflow_i[i] || ext_rx_illegal_i[i])
					err_r[i] <= 1'b1;
				else if (wr_i && cfg_i == i && wdata_i[`SLCS_RXRST])
					err_r[i] <= 1'b0;
				if (ext_credit_issued_i[i])
					cred_iss_r[i] <= 1'b1;
				else if (!link_en_o[i])
					cred_iss_r[i] <= 1'b0;
				// credit clear and the credit_reset_token pulse land in the same cycle
				if (ext_credit_got_i[i])
					cred_have_r[i] <= 1'b1;
				else if ((wr_i && cfg_i == i && wdata_i[`SLCS_CREDIT_RESET_TOKEN]) || !link_en_o[i])
					cred_have_r[i] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit pacing, one counter per external link
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_pace
			slcs_tx_pacer u_pace (
				.ref_clk_i(ref_clk_i),
				.rst_n_i(rst_n_i),
				.enable_i(link_en_o[g]),
				.sym_gap_i(symgap_r[g]),
				.tok_gap_i(tokgap_r[g]),
				.sym_sent_i(ext_sym_sent_i[g]),
				.tok_last_i(ext_tok_last_i[g]),
				.ready_o(pace_rdy[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// registered outputs: pacing, junk discard, network map
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_ready_o <= 8'h00;
			junk_drop_o <= 8'h00;
			net_o <= 32'h00000000;
		end else begin
			tx_ready_o <= pace_rdy & cred_have_r & ~ext_sym_sent_i; // sent symbol hides stale ready
			junk_drop_o <= ext_junk_i;
			for (i = 0; i < 8; i = i + 1) begin
				net_o[2*i +: 2] <= net_r[i];
				net_o[16 + 2*i +: 2] <= pnet_r[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// routing: top mismatching bit of destination picks a direction nibble
	reg [4:0] dim;
	always @* begin
		dim = top_diff(pkt_dest_i ^ node_id_i);
	end

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			route_dir_o <= 4'h0;
			route_local_o <= 1'b0;
		end else begin
			route_local_o <= dim[4];
			if (dim[4])
				route_dir_o <= 4'h0;
			else if (dim[3])
				route_dir_o <= dirs_hi_r[dim[2:0]*4 +: 4];
			else
				route_dir_o <= dirs_lo_r[dim[2:0]*4 +: 4];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses and reserved bits read zero
	reg [31:0] rd_nxt;
	always @* begin
		rd_nxt = 32'h00000000;
		if (!stat_i[3]) begin
			rd_nxt[`SLCS_SRC_HI:`SLCS_SRC_LO] = `SLCS_KIND_SWITCH;
			rd_nxt[`SLCS_DEST_HI:`SLCS_DEST_LO] = ext_dest_link_i[stat_i[2:0]*8 +: 8];
			rd_nxt[`SLCS_DIR_HI:`SLCS_DIR_LO] = dir_r[stat_i[2:0]];
			rd_nxt[`SLCS_NET_HI:`SLCS_NET_LO] = net_r[stat_i[2:0]];
			rd_nxt[`SLCS_JUNK] = ext_junk_i[stat_i[2:0]];
			rd_nxt[`SLCS_DBUSY] = ext_dst_busy_i[stat_i[2:0]];
			rd_nxt[`SLCS_SBUSY] = ext_src_busy_i[stat_i[2:0]];
		end else if (!pstat_i[3]) begin
			// same layout without direction
			rd_nxt[`SLCS_SRC_HI:`SLCS_SRC_LO] = `SLCS_KIND_PROC;
			rd_nxt[`SLCS_DEST_HI:`SLCS_DEST_LO] = plk_dest_link_i[pstat_i[2:0]*8 +: 8];
			rd_nxt[`SLCS_NET_HI:`SLCS_NET_LO] = pnet_r[pstat_i[2:0]];
			rd_nxt[`SLCS_JUNK] = plk_junk_i[pstat_i[2:0]];
			rd_nxt[`SLCS_DBUSY] = plk_dst_busy_i[pstat_i[2:0]];
			rd_nxt[`SLCS_SBUSY] = plk_src_busy_i[pstat_i[2:0]];
		end else if (!cfg_i[3]) begin
			// write-only action bits read zero
			rd_nxt[`SLCS_EN] = link_en_o[cfg_i[2:0]];
			rd_nxt[`SLCS_WIDE] = link_wide_o[cfg_i[2:0]];
			rd_nxt[`SLCS_ERR] = err_r[cfg_i[2:0]];
			rd_nxt[`SLCS_CRED_ISS] = cred_iss_r[cfg_i[2:0]];
			rd_nxt[`SLCS_CRED_HAVE] = cred_have_r[cfg_i[2:0]];
			rd_nxt[`SLCS_SYMGAP_HI:`SLCS_SYMGAP_LO] = symgap_r[cfg_i[2:0]];
			rd_nxt[`SLCS_TOKGAP_HI:`SLCS_TOKGAP_LO] = tokgap_r[cfg_i[2:0]];
		end else if (!st_i[3]) begin
			rd_nxt[`SLCS_ST_EN] = static_en_o[st_i[2:0]];
			rd_nxt[`SLCS_ST_PROC] = static_proc_o[st_i[2:0]];
			rd_nxt[`SLCS_ST_CHAN_HI:`SLCS_ST_CHAN_LO] = static_chan_o[st_i[2:0]*5 +: 5];
		end else if (addr_i == `SLCS_DIRS_LO) begin
			rd_nxt = dirs_lo_r;
		end else if (addr_i == `SLCS_DIRS_HI) begin
			rd_nxt = dirs_hi_r;
		end
	end

	// read data valid only in the cycle after the strobe
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rdata_o <= 32'h00000000;
		else if (rd_i)
			rdata_o <= rd_nxt;
		else
			rdata_o <= 32'h00000000;
	end
endmodule // slcs_link_cfg

// [slcs_link_cfg_assertions.sv]
`timescale 1ns/1ps
// watches register port, routing, link 0 outputs, all rx_reset_o bits and static_en_o[7] of the config block
module slcs_link_cfg_chk (
	input logic ref_clk_i, // clock
	input logic rst_n_i, // reset
	input logic [7:0] addr_i, // address
	input logic [31:0] wdata_i, // write data
	input logic wr_i, // write
	input logic rd_i, // read
	input logic [31:0] rdata_o, // read data
	input logic [15:0] node_id_i, // node
	input logic [15:0] pkt_dest_i, // packet dest
	input logic [3:0] route_dir_o, // direction
	input logic route_local_o, // local hit
	input logic [7:0] ext_src_busy_i, // source busy
	input logic [7:0] ext_junk_i, // junk
	input logic [7:0] ext_sym_sent_i, // symbol out
	input logic [7:0] link_en_o, // enable
	input logic [7:0] tx_ready_o, // tx ready
	input logic [7:0] send_credit_reset_token_o, // reset token
	input logic [7:0] rx_reset_o, // rx reset
	input logic [7:0] junk_drop_o, // drop
	input logic [7:0] static_en_o // static
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_cfg_wr;
		wr_i && addr_i == 8'h80;
	endsequence
	sequence s_rd(logic [7:0] a);
		rd_i && addr_i == a;
	endsequence
	////////////////////////////////////////////////////////////////
	AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not zero outside read");
	AST_EN_SET: assert property (s_cfg_wr |=> link_en_o[0] == $past(wdata_i[31]))
		else $error("link enable not taken");
	AST_CREDIT_RESET_TOKEN: assert property (s_cfg_wr ##0 wdata_i[24] |=> send_credit_reset_token_o[0])
		else $error("no reset token request");
	AST_RXRST: assert property (s_cfg_wr ##0 wdata_i[23] |=> rx_reset_o[0])
		else $error("no receiver reset");
	AST_RXRST_QUIET: assert property (!wr_i |=> rx_reset_o == 8'h00)
		else $error("receiver reset without write");
	AST_JUNK: assert property (rst_n_i && ext_junk_i[0] |=> junk_drop_o[0])
		else $error("junk packet not dropped");
	AST_EXT_KIND: assert property (s_rd(8'h20) |=> rdata_o[31:24] == 8'h00 && rdata_o[0] == $past(ext_src_busy_i[0]))
		else $error("bad external status read");
	AST_PROC_KIND: assert property (s_rd(8'h40) |=> rdata_o[25:24] == 2'h1 && rdata_o[15:6] == 10'h0)
		else $error("bad processor status read");
	AST_CFG_WO: assert property (s_rd(8'h80) |=> rdata_o[29:28] == 2'h0 && rdata_o[24:22] == 3'h0)
		else $error("write-only or reserved bits read set");
	AST_SYM_GAP: assert property (ext_sym_sent_i[0] |=> !tx_ready_o[0])
		else $error("ready right after symbol");
	AST_ROUTE_LOCAL: assert property (rst_n_i && pkt_dest_i == node_id_i |=> route_local_o && route_dir_o == 4'h0)
		else $error("local packet routed out");
	AST_STATIC: assert property (wr_i && addr_i == 8'hA7 |=> static_en_o[7] == $past(wdata_i[31]))
		else $error("last static register misplaced");
endmodule // slcs_link_cfg_chk
bind slcs_link_cfg slcs_link_cfg_chk slcs_link_cfg_chk_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.node_id_i(node_id_i), .pkt_dest_i(pkt_dest_i), .route_dir_o(route_dir_o),
	.route_local_o(route_local_o), .ext_src_busy_i(ext_src_busy_i), .ext_junk_i(ext_junk_i),
	.ext_sym_sent_i(ext_sym_sent_i), .link_en_o(link_en_o), .tx_ready_o(tx_ready_o),
	.send_credit_reset_token_o(send_credit_reset_token_o), .rx_reset_o(rx_reset_o), .junk_drop_o(junk_drop_o),
	.static_en_o(static_en_o));

// [slcs_remote_link.sv]
`timescale 1ns/1ps
// remote link end: answers reset tokens with credit, sends symbols on demand
module slcs_remote_link #(
	parameter [7:0] WIDE = 8'h01
) (
	input wire ref_clk_i, // clock
	input wire rst_n_i, // reset
	input wire slow_i, // answer late
	input wire [7:0] en_i, // link enabled
	input wire [7:0] wide_i, // five wire
	input wire [7:0] ready_i, // tx ready
	input wire [7:0] credit_reset_token_i, // reset token
	input wire [7:0] send_i, // symbols wanted
	input wire [7:0] bad_i, // inject bad token
	output reg [7:0] cgot_o, // credit arrives
	output reg [7:0] ciss_o, // credit issued
	output reg [7:0] sym_o, // symbol sent
	output reg [7:0] last_o, // token end
	output reg [7:0] bad_o // illegal token
);
	reg [7:0] h1, h2, h3;
	reg [1:0] cnt;
	wire go0 = send_i[0] & ready_i[0] & ~sym_o[0];
	////////////////////////////////////////////////////////////////
	// no answer unless enabled and wired alike, as a real far end
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{h1, h2, h3, cgot_o, ciss_o, sym_o, last_o, bad_o, cnt} <= 66'h0;
		end else begin
			h1 <= credit_reset_token_i & en_i & ~(wide_i ^ WIDE);
			h2 <= h1;
			h3 <= h2;
			cgot_o <= slow_i ? h3 : h1;
			ciss_o <= slow_i ? h3 : h1;
			// one symbol per ready window, every fourth on link 0 ends a token
			sym_o <= send_i & ready_i & en_i & ~sym_o;
			if (go0)
				cnt <= cnt + 2'h1;
			last_o <= {7'h0, go0 & (cnt == 2'h3)};
			bad_o <= bad_i & en_i;
		end
	end
endmodule // slcs_remote_link

// [slcs_link_cfg_tb.sv]
`timescale 1ns/1ps
module slcs_link_cfg_tb;
	reg ref_clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg [7:0] addr_i = 8'h00;
	reg [31:0] wdata_i = 32'h0;
	reg wr_i = 1'b0;
	reg rd_i = 1'b0;
	reg slow = 1'b0;
	reg [15:0] node = 16'h0005;
	reg [15:0] dest = 16'h0005;
	reg [15:0] m;
	reg [7:0] sbusy = 8'hA5, dbusy = 8'h3C, junk = 8'h0F, ovf = 8'h00, send = 8'h00, bad = 8'h00;
	reg [63:0] dlink = 64'h3736353433323130;
	wire [31:0] rdata_o, net;
	wire [3:0] rdir;
	wire rloc;
	wire [7:0] en, wide, rdy, credit_reset_token, rxr, jd, sen, sproc, cgot, ciss, sym, last, ill;
	wire [39:0] schan;
	integer n_mismatch = 0, n_tests = 0, i, idle = 99, plast = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	slcs_link_cfg slcs_link_cfg_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .node_id_i(node),
		.pkt_dest_i(dest), .route_dir_o(rdir), .route_local_o(rloc), .ext_src_busy_i(sbusy),
		.ext_dst_busy_i(dbusy), .ext_junk_i(junk), .ext_dest_link_i(dlink),
		.ext_rx_overflow_i(ovf), .ext_rx_illegal_i(ill), .ext_credit_issued_i(ciss),
		.ext_credit_got_i(cgot), .ext_sym_sent_i(sym), .ext_tok_last_i(last),
		.plk_src_busy_i(dbusy), .plk_dst_busy_i(sbusy), .plk_junk_i(~junk),
		.plk_dest_link_i(~dlink), .link_en_o(en), .link_wide_o(wide), .tx_ready_o(rdy),
		.send_credit_reset_token_o(credit_reset_token), .rx_reset_o(rxr), .junk_drop_o(jd), .static_en_o(sen),
		.static_proc_o(sproc), .static_chan_o(schan), .net_o(net));
	slcs_remote_link slcs_remote_link_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.slow_i(slow), .en_i(en), .wide_i(wide), .ready_i(rdy), .credit_reset_token_i(credit_reset_token),
		.send_i(send), .bad_i(bad), .cgot_o(cgot), .ciss_o(ciss), .sym_o(sym),
		.last_o(last), .bad_o(ill));
	////////////////////////////////////////////////////////////////
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge ref_clk_i);
			wr_i <= 1'b1;
			addr_i <= a;
			wdata_i <= d;
			@(posedge ref_clk_i);
			wr_i <= 1'b0;
			#1;
		end
	endtask
	// data stand only in the cycle after the strobe
	task rd(input [7:0] a, input [31:0] exp);
		begin
			@(posedge ref_clk_i);
			rd_i <= 1'b1;
			addr_i <= a;
			@(posedge ref_clk_i);
			rd_i <= 1'b0;
			#1 chk(rdata_o, exp);
		end
	endtask
	task summarize;
		begin
			$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
			if (n_mismatch == 0 && n_tests > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////
	// idle clocks between symbols, first one skipped
	always @(posedge ref_clk_i) begin
		if (sym[0]) begin
			if (idle < 99)
				chk({31'h0, idle >= (plast ? 2 : 4)}, 32'h1);
			plast = last[0];
			idle = 0;
		end else if (idle < 99)
			idle = idle + 1;
	end
	initial begin
		#100000 n_mismatch = n_mismatch + 1;
		summarize;
	end
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		// status at reset, then direction and network all ones
		for (i = 0; i < 8; i = i + 1) begin
			rd({5'h04, i[2:0]}, {8'h00, dlink[8*i+:8], 13'h0, junk[i], dbusy[i], sbusy[i]});
			rd({5'h08, i[2:0]}, {8'h01, ~dlink[8*i+:8], 13'h0, ~junk[i], sbusy[i], dbusy[i]});
			chk({31'h0, jd[i]}, {31'h0, junk[i]});
			wr({5'h04, i[2:0]}, 32'hFFFFFFFF);
			wr({5'h08, i[2:0]}, 32'hFFFFFFFF);
			chk({30'h0, net[2*i+:2]}, 32'h3);
			// processor network field of net_o lands one cycle after its write
			@(posedge ref_clk_i);
			#1 chk({30'h0, net[16+2*i+:2]}, 32'h3);
			rd({5'h04, i[2:0]}, {8'h00, dlink[8*i+:8], 8'h0F, 2'h0, 2'h3, 1'h0, junk[i], dbusy[i], sbusy[i]});
			rd({5'h08, i[2:0]}, {8'h01, ~dlink[8*i+:8], 8'h00, 2'h0, 2'h3, 1'h0, ~junk[i], sbusy[i], dbusy[i]});
		end
		rd(8'h28, 32'h0);
		rd(8'h88, 32'h0);
		rd(8'h80, 32'h0);
		// enable five wire, gaps 3 and 1, reset token and receiver
		wr(8'h80, 32'hC1801801);
		chk({30'h0, en[0], wide[0]}, 32'h3);
		repeat (5) @(posedge ref_clk_i);
		rd(8'h80, 32'hC6001801);
		slow <= 1'b1;
		wr(8'h80, 32'hC1001801);
		rd(8'h80, 32'hC4001801);
		repeat (5) @(posedge ref_clk_i);
		rd(8'h80, 32'hC6001801);
		@(posedge ref_clk_i);
		send <= 8'h01;
		repeat (80) @(posedge ref_clk_i);
		send <= 8'h00;
		// sticky error, then cleared by receiver reset
		bad <= 8'h01;
		ovf <= 8'h02;
		@(posedge ref_clk_i);
		bad <= 8'h00;
		ovf <= 8'h00;
		repeat (3) @(posedge ref_clk_i);
		rd(8'h80, 32'hCE001801);
		rd(8'h81, 32'h08000000);
		wr(8'h80, 32'hC0801801);
		rd(8'h80, 32'hC6001801);
		// static forwarding, reserved bits written as ones
		for (i = 0; i < 8; i = i + 1) begin
			wr({5'h14, i[2:0]}, {1'b1, 22'h3FFFFF, i[0], 3'h7, 2'h3, i[2:0]});
			chk({29'h0, sen[i], sproc[i], 1'b1}, {29'h0, 1'b1, i[0], 1'b1});
			chk({27'h0, schan[5*i+:5]}, {27'h0, 2'h3, i[2:0]});
			rd({5'h14, i[2:0]}, {1'b1, 22'h0, i[0], 3'h0, 2'h3, i[2:0]});
		end
		// routing by top mismatching bit, nibble k holds k
		wr(8'h0C, 32'h76543210);
		wr(8'h0D, 32'hFEDCBA98);
		@(posedge ref_clk_i);
		node <= 16'hA5C3;
		for (i = 0; i < 16; i = i + 1) begin
			m = (16'h0002 << i) - 16'h0001;
			@(posedge ref_clk_i);
			dest <= 16'hA5C3 ^ m;
			repeat (2) @(posedge ref_clk_i);
			#1 chk({27'h0, rloc, rdir}, {28'h0, i[3:0]});
		end
		@(posedge ref_clk_i);
		dest <= 16'hA5C3;
		repeat (2) @(posedge ref_clk_i);
		#1 chk({31'h0, rloc}, 32'h1);
		wr(8'h80, 32'h0);
		chk({31'h0, en[0]}, 32'h0);
		rd(8'h80, 32'h0);
		summarize;
	end
endmodule // slcs_link_cfg_tb
